// ===== shared/rcd_defs.vh
`ifndef RCD_DEFS_VH
`define RCD_DEFS_VH
// reset types reported on the dispatch outputs
`define RCD_TYPE_NONE      3'h0
`define RCD_TYPE_HOST      3'h1
`define RCD_TYPE_HOST_PC   3'h2
`define RCD_TYPE_GLOBAL    3'h3
`define RCD_TYPE_S5        3'h4
// platform reset entry timeout, in seconds, and its cycle count at 40 MHz
`define RCD_CLK_HZ         40000000
`define RCD_PLT_TMO_S      4
`define RCD_PLT_TMO_CYC    (`RCD_PLT_TMO_S * `RCD_CLK_HZ)
// wait for the processor acknowledge, default cycles
`define RCD_ACK_TMO_CYC    4000
// reset assertion time for a host reset, default cycles
`define RCD_HOLD_CYC       64
// power-off period of a power cycle, default cycles
`define RCD_PCYC_CYC       4000
`endif

// ===== src/rcd_reset_cause_dispatcher.v
`timescale 1ns/10ps
`include "rcd_defs.vh"
module rcd_reset_cause_dispatcher #(
  parameter PLT_TMO_CYC = `RCD_PLT_TMO_CYC,
  parameter ACK_TMO_CYC = `RCD_ACK_TMO_CYC,
  parameter HOLD_CYC    = `RCD_HOLD_CYC,
  parameter PCYC_CYC    = `RCD_PCYC_CYC
) (
  input  wire       clk_sys,
  input  wire       srst,
  input  wire       clk_en,
  input  wire       mc_host_reset_req,
  input  wire       mc_host_reset_pc_req,
  input  wire       mc_host_reset_pd_req,
  input  wire       mc_global_reset_req,
  input  wire       mc_pwrbtn_override,
  input  wire       mc_watchdog_timeout,
  input  wire       mc_hw_uncorr_error,
  input  wire       pm_watchdog_expired,
  input  wire       system_watchdog_second_zero,
  input  wire       processor_power_good_stuck_low,
  input  wire       plt_seq_start,
  input  wire       plt_seq_done,
  input  wire       sleep_s3_s5,
  input  wire       sleep_sw_entered,
  input  wire       wake_event,
  input  wire       deep_sleep_enable,
  input  wire       deep_sleep_cond_met,
  input  wire       reset_ack,
  output reg        reset_warn,
  output reg        platform_reset_out_n,
  output reg        host_power_on,
  output reg        global_reset,
  output reg        in_s5,
  output reg        deep_sleep_state,
  output reg  [2:0] reset_type
);

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_WARN = 7'h02;
  localparam [6:0] ST_HOLD = 7'h04;
  localparam [6:0] ST_PCYC = 7'h08;
  localparam [6:0] ST_WAKE = 7'h10;
  localparam [6:0] ST_S5   = 7'h20;
  localparam [6:0] ST_GLOB = 7'h40;

  reg [6:0]  state;
  reg [31:0] cnt;
  reg [31:0] plt_cnt;
  reg        plt_busy;
  reg        pd_pending;   // host stays off after the power cycle

  // trigger classes
  wire trig_s5;
  wire trig_glob;
  wire plt_timeout;
  assign plt_timeout = plt_busy && (plt_cnt >= PLT_TMO_CYC - 1);
  assign trig_s5 = mc_pwrbtn_override | mc_watchdog_timeout | pm_watchdog_expired
                 | mc_hw_uncorr_error;
  assign trig_glob = mc_global_reset_req | plt_timeout | processor_power_good_stuck_low;
  wire trig_pc;
  assign trig_pc = mc_host_reset_pc_req | mc_host_reset_pd_req;
  // drop host reset without power cycle in sleep
  wire trig_host;
  assign trig_host = (mc_host_reset_req | system_watchdog_second_zero) & ~sleep_s3_s5;

  // platform reset entry watchdog; restarts on each start unless completion or timeout falls in the same cycle, clears on completion
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      plt_busy <= 1'b0;
      plt_cnt  <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      if (plt_seq_done || plt_timeout)
        plt_busy <= 1'b0;
      else if (plt_seq_start)
      begin
        plt_busy <= 1'b1;
        plt_cnt  <= 32'h0000_0000;
      end
      else if (plt_busy)
        plt_cnt <= plt_cnt + 32'h0000_0001;
    end
  end

  // dispatcher; S5 and global triggers preempt lower ones in any state
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      state                <= ST_IDLE;
      cnt                  <= 32'h0000_0000;
      pd_pending           <= 1'b0;
      reset_warn           <= 1'b0;
      platform_reset_out_n <= 1'b1;
      host_power_on        <= 1'b1;
      global_reset         <= 1'b0;
      in_s5                <= 1'b0;
      deep_sleep_state     <= 1'b0;
      reset_type           <= `RCD_TYPE_NONE;
    end
    else if (clk_en)
    begin
      if (trig_s5 && state != ST_S5)
      begin
        // enter S5, power off, stay there
        state                <= ST_S5;
        reset_type           <= `RCD_TYPE_S5;
        reset_warn           <= 1'b0;
        platform_reset_out_n <= 1'b0;
        host_power_on        <= 1'b0;
        global_reset         <= 1'b0;
        in_s5                <= 1'b1;
      end
      else if (trig_glob && state != ST_S5 && state != ST_GLOB)
      begin
        state                <= ST_GLOB;
        cnt                  <= 32'h0000_0000;
        reset_type           <= `RCD_TYPE_GLOBAL;
        reset_warn           <= 1'b0;
        platform_reset_out_n <= 1'b0;
        host_power_on        <= 1'b0;
        global_reset         <= 1'b1;
      end
      else
      begin
        case (state)
          ST_IDLE:
          begin
            reset_type <= `RCD_TYPE_NONE;
            if (trig_pc && !(sleep_s3_s5 && !sleep_sw_entered))
            begin
              pd_pending <= mc_host_reset_pd_req;
              reset_type <= `RCD_TYPE_HOST_PC;
              cnt        <= 32'h0000_0000;
              if (sleep_s3_s5)
              begin
                state                <= ST_HOLD;
                platform_reset_out_n <= 1'b0;
              end
              else
              begin
                state      <= ST_WARN;
                reset_warn <= 1'b1;
              end
            end
            else if (trig_host)
            begin
              pd_pending <= 1'b0;
              reset_type <= `RCD_TYPE_HOST;
              cnt        <= 32'h0000_0000;
              state      <= ST_WARN;
              reset_warn <= 1'b1;
            end
          end
          ST_WARN:
          begin
            cnt <= cnt + 32'h0000_0001;
            // acknowledge lets the host reset go ahead
            if (reset_ack)
            begin
              reset_warn           <= 1'b0;
              platform_reset_out_n <= 1'b0;
              cnt                  <= 32'h0000_0000;
              state                <= ST_HOLD;
            end
            else if (cnt >= ACK_TMO_CYC - 1)
            begin
              reset_warn           <= 1'b0;
              platform_reset_out_n <= 1'b0;
              host_power_on        <= 1'b0;
              global_reset         <= 1'b1;
              reset_type           <= `RCD_TYPE_GLOBAL;
              cnt                  <= 32'h0000_0000;
              state                <= ST_GLOB;
            end
          end
          ST_HOLD:
          begin
            cnt <= cnt + 32'h0000_0001;
            if (cnt >= HOLD_CYC - 1)
            begin
              cnt <= 32'h0000_0000;
              if (reset_type == `RCD_TYPE_HOST_PC)
              begin
                host_power_on <= 1'b0;
                state         <= ST_PCYC;
              end
              else
              begin
                // host reset without power cycle ends here
                platform_reset_out_n <= 1'b1;
                state                <= ST_IDLE;
              end
            end
          end
          ST_PCYC:
          begin
            cnt <= cnt + 32'h0000_0001;
            if (cnt >= PCYC_CYC - 1)
            begin
              // power down variant keeps host off
              if (pd_pending)
                state <= ST_WAKE;
              else
              begin
                host_power_on        <= 1'b1;
                platform_reset_out_n <= 1'b1;
                state                <= ST_IDLE;
              end
            end
          end
          ST_WAKE:
          begin
            // finish only on an enabled wake
            if (wake_event)
            begin
              pd_pending           <= 1'b0;
              host_power_on        <= 1'b1;
              platform_reset_out_n <= 1'b1;
              state                <= ST_IDLE;
            end
          end
          ST_GLOB:
          begin
            cnt <= cnt + 32'h0000_0001;
            // power returns after the power-cycle period
            if (cnt >= PCYC_CYC - 1)
            begin
              global_reset         <= 1'b0;
              host_power_on        <= 1'b1;
              platform_reset_out_n <= 1'b1;
              state                <= ST_IDLE;
            end
          end
          ST_S5:
          begin
            // deep sleep when enabled and allowed
            deep_sleep_state <= deep_sleep_enable & deep_sleep_cond_met;
            if (wake_event)
            begin
              in_s5                <= 1'b0;
              deep_sleep_state     <= 1'b0;
              host_power_on        <= 1'b1;
              platform_reset_out_n <= 1'b1;
              state                <= ST_IDLE;
            end
          end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // rcd_reset_cause_dispatcher

// ===== verif/rcd_checker_properties.sv
`timescale 1ns/10ps
module rcd_checker #(
  parameter int PCYC_CYC = 20
) (
  input logic       clk_sys,
  input logic       srst,
  input logic       clk_en,
  input logic       mc_host_reset_req,
  input logic       mc_global_reset_req,
  input logic       mc_pwrbtn_override,
  input logic       sleep_s3_s5,
  input logic       reset_ack,
  input logic       wake_event,
  input logic       deep_sleep_enable,
  input logic       deep_sleep_cond_met,
  input logic       reset_warn,
  input logic       platform_reset_out_n,
  input logic       host_power_on,
  input logic       global_reset,
  input logic       in_s5,
  input logic       deep_sleep_state,
  input logic [2:0] reset_type
);
  localparam int PMAX = PCYC_CYC + 2;
  default clocking @(posedge clk_sys); endclocking
  // a frozen block holds its state, so no timing claim runs across a freeze
  default disable iff (srst || !clk_en);
  // idle and a host request with no override or global request; other triggers outrank it
  wire idle = reset_type == 3'h0 && !in_s5 && !global_reset && !reset_warn;
  wire hreq = idle && mc_host_reset_req && !mc_pwrbtn_override && !mc_global_reset_req;
  // power must stay off a while before it may come back
  sequence s_off;
    (!host_power_on && !platform_reset_out_n) [*8];
  endsequence
  chk_global_start: assert property (
    mc_global_reset_req && !mc_pwrbtn_override && !in_s5 && !global_reset
    |=> global_reset && !reset_warn && reset_type == 3'h3) else $error("global start wrong");
  chk_global_pcyc: assert property (
    $rose(global_reset) |-> s_off ##[1:PMAX] host_power_on) else $error("power cycle wrong");
  chk_s5_entry: assert property (
    mc_pwrbtn_override && !in_s5 |=> in_s5 && !host_power_on && reset_type == 3'h4)
    else $error("off entry wrong");
  chk_deep_sleep: assert property (
    in_s5 && deep_sleep_enable && deep_sleep_cond_met && !wake_event |=> in_s5 && deep_sleep_state)
    else $error("deep sleep missed");
  chk_host_warn: assert property (
    hreq && !sleep_s3_s5 |=> reset_warn && reset_type == 3'h1) else $error("no warning");
  chk_host_drop: assert property (
    hreq && sleep_s3_s5 |=> idle) else $error("host request not dropped");
  chk_ack_reset: assert property (
    reset_warn && reset_ack && !mc_pwrbtn_override && !mc_global_reset_req
    |=> !reset_warn && !platform_reset_out_n) else $error("ack not followed by reset");
  chk_ack_escalate: assert property (
    $fell(reset_warn) && !$past(reset_ack) && !$past(srst) |-> global_reset || in_s5)
    else $error("no escalation");
endmodule // rcd_checker
bind rcd_reset_cause_dispatcher rcd_checker #(.PCYC_CYC(PCYC_CYC)) rcd_checker_i (
  .clk_sys, .srst, .clk_en, .mc_host_reset_req, .mc_global_reset_req, .mc_pwrbtn_override,
  .sleep_s3_s5, .reset_ack, .wake_event, .deep_sleep_enable, .deep_sleep_cond_met,
  .reset_warn, .platform_reset_out_n, .host_power_on, .global_reset, .in_s5,
  .deep_sleep_state, .reset_type
);

// ===== verif/rcd_proc_model.sv
`timescale 1ns/10ps
module rcd_proc_model (
  input  logic       clk_sys,
  input  logic       reset_warn,
  input  logic [1:0] ack_mode,
  output logic       reset_ack
);
  logic [4:0] wait_cnt = 5'h0;
  logic       ack_q    = 1'b0;
  // one driver for the acknowledge output
  assign reset_ack = ack_q;
  // acknowledge each warning except in mode 2
  // mode 0 answers at once, 1 after eight cycles, 2 never so escalation can be seen
  always @(posedge clk_sys)
  begin
    wait_cnt <= reset_warn ? wait_cnt + 5'h1 : 5'h0;
    ack_q <= reset_warn && ack_mode != 2'h2 && wait_cnt >= (ack_mode == 2'h0 ? 5'h0 : 5'h8);
  end
endmodule // rcd_proc_model

// ===== verif/reset_cause_dispatcher_tb_top.sv
`timescale 1ns/10ps
module reset_cause_dispatcher_tb_top;
  logic       clk_sys = 1'b0;
  logic       srst = 1'b1;
  logic       run_en = 1'b1;
  logic [9:0] trig = 10'h000;
  logic       p_go = 0, p_ok = 0, slp = 0, sw = 0, wake = 0, ds_en = 0, ds_ok = 0;
  logic       warn, ack, plt_n, pwr, glob, s5, ds;
  logic [2:0] rtype;
  logic [1:0] ack_mode = 2'h0;
  int         n_mismatch = 0;
  int         n_checks = 0;
  initial forever #12.5 clk_sys = ~clk_sys;
  rcd_reset_cause_dispatcher #(.PLT_TMO_CYC(200), .ACK_TMO_CYC(20), .HOLD_CYC(4), .PCYC_CYC(20))
  rcd_reset_cause_dispatcher_i (
    .clk_sys(clk_sys), .srst(srst), .clk_en(run_en), .mc_host_reset_req(trig[0]),
    .mc_host_reset_pc_req(trig[1]), .mc_host_reset_pd_req(trig[2]),
    .mc_global_reset_req(trig[3]), .mc_pwrbtn_override(trig[4]), .mc_watchdog_timeout(trig[5]),
    .mc_hw_uncorr_error(trig[6]), .pm_watchdog_expired(trig[7]),
    .system_watchdog_second_zero(trig[8]), .processor_power_good_stuck_low(trig[9]),
    .plt_seq_start(p_go), .plt_seq_done(p_ok), .sleep_s3_s5(slp), .sleep_sw_entered(sw),
    .wake_event(wake), .deep_sleep_enable(ds_en), .deep_sleep_cond_met(ds_ok), .reset_ack(ack),
    .reset_warn(warn), .platform_reset_out_n(plt_n), .host_power_on(pwr), .global_reset(glob),
    .in_s5(s5), .deep_sleep_state(ds), .reset_type(rtype));
  rcd_proc_model rcd_proc_model_i (
    .clk_sys(clk_sys), .reset_warn(warn), .ack_mode(ack_mode), .reset_ack(ack));
  task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // a one-cycle pulse; the outputs have answered when this returns
  task automatic fire(input int b);
    @(negedge clk_sys) trig[b] = 1'b1;
    @(negedge clk_sys) trig[b] = 1'b0;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 300 && !(rtype === 3'h0 && pwr === 1'b1 && plt_n === 1'b1); i++) cyc(1);
    chk("idle", 3'h0, rtype);
  endtask
  // both host sources, acknowledged promptly, slowly, never
  task automatic t_host;
    for (int m = 0; m < 4; m++)
    begin
      // passes 0 and 2 answer at once, pass 1 late, pass 3 never
      ack_mode = (m == 3) ? 2'h2 : {1'b0, m[0]};
      fire(m == 1 ? 8 : 0);
      chk("warn", 3'h1, warn);
      chk("host type", 3'h1, rtype);
      for (int i = 0; i < 40 && warn === 1'b1; i++) cyc(1);
      chk("plt", 3'h0, plt_n);
      chk("global", m == 3, glob);
      wait_idle;
    end
    ack_mode = 2'h0;
    $display("host done");
  endtask
  task automatic t_global;
    for (int b = 3; b < 10; b += 6)
    begin
      fire(b);
      chk("global", 3'h1, glob);
      chk("warn", 3'h0, warn);
      chk("type", 3'h3, rtype);
      chk("power", 3'h0, pwr);
      wait_idle;
      chk("power back", 3'h1, pwr);
    end
    // a low clock enable freezes the power cycle well past its length
    fire(3);
    @(negedge clk_sys) run_en = 1'b0;
    cyc(30);
    chk("frozen", 3'h1, glob);
    chk("frozen power", 3'h0, pwr);
    @(negedge clk_sys) run_en = 1'b1;
    wait_idle;
    @(negedge clk_sys) p_go = 1;
    @(negedge clk_sys) p_go = 0;
    @(negedge clk_sys) p_ok = 1;
    @(negedge clk_sys) p_ok = 0;
    cyc(220);
    chk("done seq", 3'h0, glob);
    @(negedge clk_sys) p_go = 1;
    @(negedge clk_sys) p_go = 0;
    for (int i = 0; i < 230 && glob !== 1'b1; i++) cyc(1);
    chk("seq timeout", 3'h1, glob);
    wait_idle;
    $display("global done");
  endtask
  task automatic t_s5;
    for (int b = 4; b < 8; b++)
    begin
      ds_en = b[0];
      ds_ok = 1;
      fire(b);
      chk("off", 3'h1, s5);
      chk("off type", 3'h4, rtype);
      fire(3);
      cyc(2);
      chk("stays off", 3'h1, s5);
      chk("deep", b[0], ds);
      @(negedge clk_sys) wake = 1;
      @(negedge clk_sys) wake = 0;
      wait_idle;
    end
    $display("off done");
  endtask
  // requests in software sleep, then power down with wake
  task automatic t_sleep;
    slp = 1;
    sw = 1;
    fire(0);
    chk("dropped", 3'h0, rtype);
    fire(1);
    chk("no warn", 3'h0, warn);
    chk("pc type", 3'h2, rtype);
    wait_idle;
    // sleep not entered by software drops the power-cycled request too
    sw = 0;
    fire(1);
    chk("pc dropped", 3'h0, rtype);
    slp = 0;
    fire(2);
    chk("pd type", 3'h2, rtype);
    cyc(60);
    chk("stays down", 3'h0, pwr);
    @(negedge clk_sys) wake = 1;
    @(negedge clk_sys) wake = 0;
    wait_idle;
    $display("sleep done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    cyc(10);
    srst = 0;
    t_host;
    t_global;
    t_s5;
    t_sleep;
    wrap_up;
  end
  // cut a hang short well past the expected run
  initial
  begin
    #(25 * 8000);
    n_mismatch++;
    wrap_up;
  end
endmodule // reset_cause_dispatcher_tb_top
